// File: bench/test_supply_warning_and_clock_gates.sv
// self-checking bench for the supply warning and clock gate register bank
// assumes swcg_top drives the axi4-lite slave; the bench is the only master
`timescale 1ns/1ps
module test_supply_warning_and_clock_gates;
  import swcg_pkg::*;
  logic aclk;
  logic aresetn;
  logic power_on_reset;
  logic supply_below_warning;
  logic [ADDR_W-1:0] awaddr;
  logic awvalid;
  logic awready;
  logic [DATA_W-1:0] wdata;
  logic [STRB_W-1:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [ADDR_W-1:0] araddr;
  logic arvalid;
  logic arready;
  logic [DATA_W-1:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  logic warning_irq;
  logic det_sel;
  logic warn_sel;
  logic [7:0] g1;
  logic [7:0] g2;
  logic [1:0] resp;
  logic [DATA_W-1:0] rdat;
  logic [7:0] d1;
  logic [7:0] d2;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed;

  swcg_top dut_u (
    .aclk(aclk), .aresetn(aresetn), .power_on_reset(power_on_reset),
    .supply_below_warning(supply_below_warning),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .warning_irq(warning_irq), .detect_trip_select(det_sel), .warning_trip_select(warn_sel),
    .second_reference_gate(g1[7]), .second_timer_gate(g1[6]), .first_timer_gate(g1[5]),
    .converter_gate(g1[4]), .first_reference_gate(g1[3]), .two_wire_bus_gate(g1[2]),
    .second_serial_gate(g1[1]), .first_serial_gate(g1[0]),
    .debug_gate(g2[7]), .ext_interrupt_gate(g2[5]), .keyboard_interrupt_gate(g2[4]),
    .comparator_gate(g2[3]), .time_of_day_gate(g2[2]), .display_driver_gate(g2[1]),
    .serial_periph_gate(g2[0])
  );
  assign g2[6] = 1'b0;

  // 200 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // expected control readback from its fields
  function automatic logic [31:0] exp_ctrl(logic f, logic dv, logic wv, logic ie);
    return {24'h0, f, 1'b0, dv, wv, ie, 3'h0};
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one axi write, holds each channel until its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'h1);
    int n;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 100) check("write answer", 32'h0, 32'h1);
  endtask

  // one axi read
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rdat = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 100) check("read answer", 32'h0, 32'h1);
  endtask

  task automatic do_reset(input logic por);
    @(posedge aclk);
    aresetn <= 1'b0;
    power_on_reset <= por;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    power_on_reset <= 1'b0;
    @(posedge aclk);
  endtask

  // cycle ceiling against hangs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end

  initial begin
    aresetn = 1'b0;
    power_on_reset = 1'b1;
    supply_below_warning = 1'b0;
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wstrb = '0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
    seed = $urandom(35133);
    do_reset(1'b1);
    // reset values
    rd(WARN_CTRL_OFF);
    check("ctrl reset", rdat, exp_ctrl(0, 0, 0, 0));
    rd(GATE_ONE_OFF);
    check("gate one reset", rdat, 32'h0000_00ff);
    rd(GATE_TWO_OFF);
    check("gate two reset", rdat, {24'h0, GATE_TWO_RST});
    check("gate ports reset", {g1, g2}, {8'hff, GATE_TWO_RST});
    // gate registers: corners then random
    for (int i = 0; i < 12; i++) begin
      d1 = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      d2 = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      wr(GATE_ONE_OFF, {24'($urandom), d1});
      check("gate one resp", resp, RESP_OKAY);
      wr(GATE_TWO_OFF, {24'($urandom), d2});
      check("gate two resp", resp, RESP_OKAY);
      rd(GATE_ONE_OFF);
      check("gate one read", rdat, {24'h0, d1});
      check("gate one rresp", resp, RESP_OKAY);
      rd(GATE_TWO_OFF);
      check("gate two read", rdat, {24'h0, d2 & 8'hbf});
      check("gate one ports", g1, d1);
      check("gate two ports", g2, d2 & 8'hbf);
    end
    // unmapped address and disabled byte lane
    wr(8'h0c, 32'($urandom));
    check("unmapped write resp", resp, RESP_SLVERR);
    rd(8'h0c);
    check("unmapped read resp", resp, RESP_SLVERR);
    check("unmapped read data", rdat, 32'h0);
    wr(GATE_ONE_OFF, 32'h0000_005a, 4'he);
    rd(GATE_ONE_OFF);
    check("strobe off no write", rdat, {24'h0, d1});
    // every trip select code, including the discouraged one
    for (int c = 0; c < 4; c++) begin
      wr(WARN_CTRL_OFF, {26'h0, 2'(c), 4'h0});
      check("detect select", det_sel, c[1]);
      check("warning select", warn_sel, c[0]);
      rd(WARN_CTRL_OFF);
      check("ctrl selects", rdat, exp_ctrl(0, c[1], c[0], 0));
    end
    // flag sets, ack refused while present, irq follows enable
    supply_below_warning <= 1'b1;
    repeat (10) @(posedge aclk);
    check("irq masked", warning_irq, 1'b0);
    rd(WARN_CTRL_OFF);
    check("flag set", rdat, exp_ctrl(1, 1, 1, 0));
    wr(WARN_CTRL_OFF, 32'h0000_0048);
    rd(WARN_CTRL_OFF);
    check("ack while low", rdat, exp_ctrl(1, 0, 0, 1));
    repeat (2) @(posedge aclk);
    check("irq raised", warning_irq, 1'b1);
    supply_below_warning <= 1'b0;
    repeat (10) @(posedge aclk);
    rd(WARN_CTRL_OFF);
    check("flag sticky", rdat, exp_ctrl(1, 0, 0, 1));
    wr(WARN_CTRL_OFF, 32'h0000_0048);
    rd(WARN_CTRL_OFF);
    check("ack clears", rdat, exp_ctrl(0, 0, 0, 1));
    repeat (2) @(posedge aclk);
    check("irq dropped", warning_irq, 1'b0);
    // other reset keeps selects; flag returns if supply already low
    wr(WARN_CTRL_OFF, 32'h0000_0038);
    wr(GATE_ONE_OFF, 32'h0000_0000);
    supply_below_warning <= 1'b1;
    do_reset(1'b0);
    check("selects held", {det_sel, warn_sel}, 2'h3);
    check("gate one after reset", g1, 8'hff);
    repeat (10) @(posedge aclk);
    rd(WARN_CTRL_OFF);
    check("ctrl after reset", rdat, exp_ctrl(1, 1, 1, 0));
    check("irq after reset", warning_irq, 1'b0);
    // power-on reset clears the selects
    supply_below_warning <= 1'b0;
    do_reset(1'b1);
    repeat (10) @(posedge aclk);
    rd(WARN_CTRL_OFF);
    check("ctrl after por", rdat, exp_ctrl(0, 0, 0, 0));
    close_out();
  end
endmodule

// File: core/swcg_gate_reg.sv
// one byte-wide clock gate register; each implemented bit is a gate enable flop
// assumes a one-cycle write strobe from the bus slave in the same clock domain
`timescale 1ns/1ps
module swcg_gate_reg
  import swcg_pkg::*;
#(
  parameter logic [REG_W-1:0] RESET_VAL = GATE_ONE_RST,
  parameter logic [REG_W-1:0] IMPL_MASK = GATE_ONE_MASK
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input wire logic [REG_W-1:0] wr_data,
  output logic [REG_W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < REG_W; i++) begin : g_bit
      if (IMPL_MASK[i]) begin : g_impl
        logic bit_q;
        logic next_q;
        // load on write, else hold
        always_comb begin
          next_q = wr_en ? wr_data[i] : bit_q;
        end
        // gate flop, every reset restores its reset value
        always_ff @(posedge aclk) begin
          if (!aresetn) begin
            bit_q <= RESET_VAL[i];
          end else begin
            bit_q <= next_q;
          end
        end
        // own flop per bit keeps the output vector free of mixed drivers
        assign q[i] = bit_q;
      end else begin : g_none
        // unimplemented bit reads zero
        assign q[i] = 1'h0;
      end
    end
  endgenerate

endmodule

// File: core/swcg_pkg.sv
// constants for the supply warning and peripheral clock gate register bank
// assumes an axi4-lite master with 32-bit data and byte addresses
package swcg_pkg;

  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int PAD_W = DATA_W - REG_W;
  localparam int STRB_W = DATA_W / 8;
  localparam int LANE0 = 0;

  // register byte offsets
  localparam logic [ADDR_W-1:0] WARN_CTRL_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] GATE_ONE_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] GATE_TWO_OFF = 8'h08;

  // supply_warning_control fields
  localparam int FLAG_BIT = 7;
  localparam int ACK_BIT = 6;
  localparam int DET_SEL_BIT = 5;
  localparam int WARN_SEL_BIT = 4;
  localparam int IE_BIT = 3;
  localparam logic FLAG_RST = 1'h0;
  localparam logic IE_RST = 1'h0;
  localparam logic TRIP_SEL_POR = 1'h0;

  // peripheral_clock_gate_one fields
  localparam int G1_SECOND_REF = 7;
  localparam int G1_SECOND_TIMER = 6;
  localparam int G1_FIRST_TIMER = 5;
  localparam int G1_CONVERTER = 4;
  localparam int G1_FIRST_REF = 3;
  localparam int G1_TWO_WIRE = 2;
  localparam int G1_SECOND_SERIAL = 1;
  localparam int G1_FIRST_SERIAL = 0;
  localparam logic [REG_W-1:0] GATE_ONE_RST = 8'hff;
  localparam logic [REG_W-1:0] GATE_ONE_MASK = 8'hff;

  // peripheral_clock_gate_two fields, bit 6 unimplemented
  localparam int G2_DEBUG = 7;
  localparam int G2_EXT_IRQ = 5;
  localparam int G2_KEYBOARD = 4;
  localparam int G2_COMPARATOR = 3;
  localparam int G2_TIME_OF_DAY = 2;
  localparam int G2_DISPLAY = 1;
  localparam int G2_SERIAL_PERIPH = 0;
  localparam logic [REG_W-1:0] GATE_TWO_RST = 8'hbf;
  localparam logic [REG_W-1:0] GATE_TWO_MASK = 8'hbf;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: core/swcg_sync.sv
// three-stage synchroniser for the warning comparator output
// assumes the input is asynchronous to aclk; output changes once stages two and three agree
`timescale 1ns/1ps
module swcg_sync
  import swcg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic async_in,
  output logic sync_out
);

  logic stage1;
  logic stage2;
  logic stage3;
  logic next_stage1;
  logic next_stage2;
  logic next_stage3;
  logic next_sync_out;

  // stage one feeds stage two only
  always_comb begin
    next_stage1 = async_in;
    next_stage2 = stage1;
    next_stage3 = stage2;
    next_sync_out = (stage2 == stage3) ? stage2 : sync_out;
  end

  // chain registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= 1'h0;
      stage2 <= 1'h0;
      stage3 <= 1'h0;
      sync_out <= 1'h0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
      stage3 <= next_stage3;
      sync_out <= next_sync_out;
    end
  end

endmodule

// File: core/swcg_top.sv
// supply warning control and peripheral bus-clock gate registers behind axi4-lite
// assumes a comparator that reports the supply below the selected warning level,
// a reset controller that marks power-on resets, and clock gate cells in the clock tree
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module swcg_top
  import swcg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic power_on_reset,
  input wire logic supply_below_warning,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic warning_irq,
  output logic detect_trip_select,
  output logic warning_trip_select,
  output logic second_reference_gate,
  output logic second_timer_gate,
  output logic first_timer_gate,
  output logic converter_gate,
  output logic first_reference_gate,
  output logic two_wire_bus_gate,
  output logic second_serial_gate,
  output logic first_serial_gate,
  output logic debug_gate,
  output logic ext_interrupt_gate,
  output logic keyboard_interrupt_gate,
  output logic comparator_gate,
  output logic time_of_day_gate,
  output logic display_driver_gate,
  output logic serial_periph_gate
);

  logic warn_cond;
  logic [ADDR_W-1:0] waddr;
  logic [REG_W-1:0] wbyte;
  logic wlane;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic [ADDR_W-1:0] next_waddr;
  logic [REG_W-1:0] next_wbyte;
  logic next_wlane;
  logic do_write;
  logic wr_hit;
  logic wr_warn;
  logic wr_gate_one;
  logic wr_gate_two;
  logic next_arready;
  logic next_rvalid;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0] next_rresp;
  logic [REG_W-1:0] rd_byte;
  logic rd_hit;
  logic warn_flag;
  logic warn_ie;
  logic next_warn_flag;
  logic next_warn_ie;
  logic next_detect_sel;
  logic next_warn_sel;
  logic next_irq;
  logic ack_clear;
  logic [REG_W-1:0] gate_one;
  logic [REG_W-1:0] gate_two;
  logic [REG_W-1:0] warn_reg;

  // comparator output brought onto aclk
  swcg_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(supply_below_warning),
    .sync_out(warn_cond)
  );

  // write channel: address and data captured in either order, then one register write
  always_comb begin
    next_awready = s_axi_awready;
    next_wready = s_axi_wready;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_waddr = waddr;
    next_wbyte = wbyte;
    next_wlane = wlane;
    if (s_axi_awvalid && s_axi_awready) begin
      next_awready = 1'h0;
      next_waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wready = 1'h0;
      next_wbyte = s_axi_wdata[REG_W-1:0];
      next_wlane = s_axi_wstrb[LANE0];
    end
    if (do_write) begin
      next_bvalid = 1'h1;
      next_bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'h0;
      next_awready = 1'h1;
      next_wready = 1'h1;
    end
  end

  // write decode; a write without lane zero changes nothing
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_hit = (waddr == WARN_CTRL_OFF) || (waddr == GATE_ONE_OFF) || (waddr == GATE_TWO_OFF);
  assign wr_warn = do_write && wlane && (waddr == WARN_CTRL_OFF);
  assign wr_gate_one = do_write && wlane && (waddr == GATE_ONE_OFF);
  assign wr_gate_two = do_write && wlane && (waddr == GATE_TWO_OFF);

  // write channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'h1;
      s_axi_wready <= 1'h1;
      s_axi_bvalid <= 1'h0;
      s_axi_bresp <= RESP_OKAY;
      waddr <= '0;
      wbyte <= '0;
      wlane <= 1'h0;
    end else begin
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      waddr <= next_waddr;
      wbyte <= next_wbyte;
      wlane <= next_wlane;
    end
  end

  // readable image of the warning register, acknowledge and low bits zero
  always_comb begin
    warn_reg = '0;
    warn_reg[FLAG_BIT] = warn_flag;
    warn_reg[DET_SEL_BIT] = detect_trip_select;
    warn_reg[WARN_SEL_BIT] = warning_trip_select;
    warn_reg[IE_BIT] = warn_ie;
  end

  // read mux, unmapped addresses read zero with an error response
  always_comb begin
    rd_byte = '0;
    rd_hit = 1'h1;
    unique case (s_axi_araddr)
      WARN_CTRL_OFF: rd_byte = warn_reg;
      GATE_ONE_OFF: rd_byte = gate_one;
      GATE_TWO_OFF: rd_byte = gate_two;
      default: rd_hit = 1'h0;
    endcase
  end

  // read channel: sample on the address handshake, hold until taken
  always_comb begin
    next_arready = s_axi_arready;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'h0;
      next_rvalid = 1'h1;
      next_rdata = {{PAD_W{1'h0}}, rd_byte};
      next_rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'h0;
      next_arready = 1'h1;
    end
  end

  // read channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'h1;
      s_axi_rvalid <= 1'h0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // warning flag, selects, enable and interrupt request
  always_comb begin
    ack_clear = wr_warn && wbyte[ACK_BIT] && !warn_cond;
    next_warn_flag = warn_cond || (warn_flag && !ack_clear);
    next_warn_ie = wr_warn ? wbyte[IE_BIT] : warn_ie;
    next_detect_sel = wr_warn ? wbyte[DET_SEL_BIT] : detect_trip_select;
    next_warn_sel = wr_warn ? wbyte[WARN_SEL_BIT] : warning_trip_select;
    next_irq = warn_flag && warn_ie;
  end

  // flag, enable and request clear on every reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      warn_flag <= FLAG_RST;
      warn_ie <= IE_RST;
      warning_irq <= 1'h0;
    end else begin
      warn_flag <= next_warn_flag;
      warn_ie <= next_warn_ie;
      warning_irq <= next_irq;
    end
  end

  // trip selects survive every reset except power-on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      if (power_on_reset) begin
        detect_trip_select <= TRIP_SEL_POR;
        warning_trip_select <= TRIP_SEL_POR;
      end
    end else begin
      detect_trip_select <= next_detect_sel;
      warning_trip_select <= next_warn_sel;
    end
  end

  // first gate register, all gates open after reset
  swcg_gate_reg #(
    .RESET_VAL(GATE_ONE_RST),
    .IMPL_MASK(GATE_ONE_MASK)
  ) u_gate_one (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(wr_gate_one),
    .wr_data(wbyte),
    .q(gate_one)
  );

  // second gate register, bit 6 unimplemented
  swcg_gate_reg #(
    .RESET_VAL(GATE_TWO_RST),
    .IMPL_MASK(GATE_TWO_MASK)
  ) u_gate_two (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(wr_gate_two),
    .wr_data(wbyte),
    .q(gate_two)
  );

  // first gate bank enables, one per peripheral
  assign second_reference_gate = gate_one[G1_SECOND_REF];
  assign second_timer_gate = gate_one[G1_SECOND_TIMER];
  assign first_timer_gate = gate_one[G1_FIRST_TIMER];
  assign converter_gate = gate_one[G1_CONVERTER];
  assign first_reference_gate = gate_one[G1_FIRST_REF];
  assign two_wire_bus_gate = gate_one[G1_TWO_WIRE];
  assign second_serial_gate = gate_one[G1_SECOND_SERIAL];
  assign first_serial_gate = gate_one[G1_FIRST_SERIAL];

  // second gate bank; tod and display enables gate the bus clock only
  assign debug_gate = gate_two[G2_DEBUG];
  assign ext_interrupt_gate = gate_two[G2_EXT_IRQ];
  assign keyboard_interrupt_gate = gate_two[G2_KEYBOARD];
  assign comparator_gate = gate_two[G2_COMPARATOR];
  assign time_of_day_gate = gate_two[G2_TIME_OF_DAY];
  assign display_driver_gate = gate_two[G2_DISPLAY];
  assign serial_periph_gate = gate_two[G2_SERIAL_PERIPH];

  // checks on the register behaviour
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence ack_while_low_s;
    wr_warn && wbyte[ACK_BIT] && warn_cond;
  endsequence

  sequence write_taken_s;
    do_write ##1 s_axi_bvalid;
  endsequence

  flag_sets_a: assert property (warn_cond |=> warn_flag)
    else $error("warning flag not set by low supply");
  flag_sticky_a: assert property (warn_flag && !wr_warn |=> warn_flag [*1])
    else $error("warning flag dropped without acknowledge");
  ack_clears_a: assert property (wr_warn && wbyte[ACK_BIT] && !warn_cond |=> !warn_flag)
    else $error("acknowledge did not clear flag");
  ack_blocked_a: assert property (ack_while_low_s |=> warn_flag ##1 warn_flag)
    else $error("acknowledge cleared flag while supply low");
  detect_sel_a: assert property (wr_warn |=> detect_trip_select == $past(wbyte[DET_SEL_BIT]))
    else $error("detect trip select not loaded");
  warn_sel_a: assert property (wr_warn |=> warning_trip_select == $past(wbyte[WARN_SEL_BIT]))
    else $error("warning trip select not loaded");
  irq_request_a: assert property (warning_irq == $past(warn_flag && warn_ie))
    else $error("interrupt request wrong");
  gate_one_a: assert property (wr_gate_one |=> gate_one == $past(wbyte))
    else $error("first gate register not loaded");
  gate_two_a: assert property (wr_gate_two |=> gate_two == ($past(wbyte) & GATE_TWO_MASK))
    else $error("second gate register wrong");
  comparator_gate_a: assert property (wr_gate_two |=>
    comparator_gate == $past(wbyte[G2_COMPARATOR]))
    else $error("comparator gate not loaded");
  sel_keep_a: assert property (@(posedge aclk) disable iff (1'h0)
    !aresetn && !power_on_reset |=> detect_trip_select == $past(detect_trip_select))
    else $error("trip select lost on non power-on reset");
  gate_reset_a: assert property (@(posedge aclk) disable iff (1'h0)
    !aresetn |=> gate_one == GATE_ONE_RST)
    else $error("first gate register reset wrong");
  write_resp_a: assert property (do_write |-> write_taken_s)
    else $error("write response missing");

endmodule
